// *** spi_pkg.sv ***
// Constants for the buffered serial port block
package spi_pkg;
  localparam logic [7:0] STAT_OFS = 8'h00;
  localparam logic [7:0] CON1_OFS = 8'h04;
  localparam logic [7:0] CON2_OFS = 8'h08;
  localparam logic [7:0] BUF_OFS = 8'h0C;
  localparam int EN_BIT = 15;
  localparam int SIDL_BIT = 13;
  localparam int BEC_LSB = 8;
  localparam int SHIFT_REGISTER_EMPTY_FLAG_BIT = 7;
  localparam int ROV_BIT = 6;
  localparam int RECEIVE_FIFO_EMPTY_FLAG_BIT = 5;
  localparam int BUFFER_INTERRUPT_MODE_LSB = 2;
  localparam int TBF_BIT = 1;
  localparam int RBF_BIT = 0;
  localparam int WORD_WIDTH_SELECT_BIT_BIT = 10;
  localparam int CKE_BIT = 8;
  localparam int SLAVE_SELECT_ENABLE_BIT_BIT = 7;
  localparam int CKP_BIT = 6;
  localparam int MASTER_SELECT_BIT_BIT = 5;
  localparam int BEN_BIT = 0;
  localparam logic [15:0] CON1_MASK = 16'h1FFF;
  localparam logic [15:0] CON2_MASK = 16'hE003;
  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_NS = 10;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    SI_RX_EMPTIED = 3'b000, SI_RX_AVAIL = 3'b001, SI_RX_3Q = 3'b010, SI_RX_FULL = 3'b011,
    SI_TX_MOVED = 3'b100, SI_TX_DONE = 3'b101, SI_TX_LAST = 3'b110, SI_TX_FULL = 3'b111
  } buffer_interrupt_mode_t;
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_RUN = 2'b01
  } xfer_t;
endpackage

// *** spi_buffer_status_control.sv ***
// Serial port with standard and FIFO-buffered modes, AHB-Lite registers
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - master starts shifting on buffer write
// - enable bit owns pins, clear disables
// - idle-stop bit halts during Idle mode
// - element count shows pending or unread
// - shift register empty flag
// - overflow sets, drops word, software clears
// - receive FIFO empty flag
// - transmit interrupt mode codes
// - receive interrupt mode codes
// - standard transmit full flag behaviour
// - enhanced transmit full on last slot
// - standard receive full flag behaviour
// - enhanced receive full on last slot
// - single buffer or eight-entry FIFO
// - word width sixteen or eight bits
module spi_buffer_status_control #(
  parameter int DEPTH = spi_pkg::FIFO_DEPTH,
  parameter int SCK_HALF = spi_pkg::SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic idle_mode,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_n,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe_n,
  input wire logic serial_data_in_pin,
  input wire logic slave_select_pin_n,
  output logic buffer_event
);
  import spi_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [2:0] sy1_r, sy2_r;
  logic hready_r, pend_r, pw_r, hresp_r;
  logic [7:0] pa_r;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic en_r, en_nxt, sidl_r, sidl_nxt, rov_r, rov_nxt, evt_r, evt_nxt;
  logic [2:0] buffer_interrupt_mode_r, buffer_interrupt_mode_nxt;
  logic [15:0] con1_r, con1_nxt, con2_r, con2_nxt;
  logic [15:0] tx_mem [DEPTH];
  logic [15:0] rx_mem [DEPTH];
  logic [AW-1:0] twp_r, twp_nxt, trp_r, trp_nxt, rwp_r, rwp_nxt, rrp_r, rrp_nxt;
  logic [CW-1:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt, cap;
  xfer_t st_r, st_nxt;
  logic [15:0] sr_r, sr_nxt, rxs_r, rxs_nxt, rx_word;
  logic [4:0] bit_r, bit_nxt;
  logic [5:0] tog_r, tog_nxt;
  logic [7:0] div_r, div_nxt;
  logic sck_r, sck_nxt, prev_r, sdo_r, sdo_nxt, sck_oe_r, sdo_oe_r;
  logic run, master_select_bit, ben, word_width_select_bit, cke, ckp, sel, lvl, act, samp, shft, div_wrap;
  logic load, done, push, pop, wr_stat, rd_buf, ovf;
  logic [4:0] nbits;

  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign shift_clock_pin_out = sck_r;
  assign shift_clock_pin_oe_n = sck_oe_r;
  assign serial_data_out_pin = sdo_r;
  assign serial_data_out_pin_oe_n = sdo_oe_r;
  assign buffer_event = evt_r;

  always_comb
  begin
    master_select_bit = con1_r[MASTER_SELECT_BIT_BIT];
    ben = con2_r[BEN_BIT];
    word_width_select_bit = con1_r[WORD_WIDTH_SELECT_BIT_BIT];
    cke = con1_r[CKE_BIT];
    ckp = con1_r[CKP_BIT];
    nbits = word_width_select_bit ? 5'h10 : 5'h08;
    cap = ben ? CW'(DEPTH) : CW'(1);
    run = en_r && !(sidl_r && idle_mode);
    sel = master_select_bit || !con1_r[SLAVE_SELECT_ENABLE_BIT_BIT] || !sy2_r[2];
    lvl = master_select_bit ? sck_r : sy2_r[0];
    act = lvl ^ ckp;
    // Sample on the edge opposite the data change edge
    samp = run && sel && (lvl != prev_r) && (act == cke);
    shft = run && sel && (lvl != prev_r) && (act != cke);
    div_wrap = div_r == 8'(SCK_HALF - 1);
    wr_stat = pend_r && pw_r && pa_r == STAT_OFS;
    rd_buf = pend_r && !pw_r && pa_r == BUF_OFS;
    push = pend_r && pw_r && pa_r == BUF_OFS && tcnt_r < cap;
    pop = rd_buf && rcnt_r != '0;
    load = run && st_r == XF_IDLE && tcnt_r != '0;
    rxs_nxt = samp ? {rxs_r[14:0], sy2_r[1]} : rxs_r;
    done = st_r == XF_RUN && (master_select_bit ? (tog_r == 6'({nbits, 1'b0}) && div_wrap)
                                    : (samp && bit_r == nbits - 5'h01));
    if (!master_select_bit && samp && bit_r == nbits - 5'h01)
    begin
      done = 1'b1;
    end
    rx_word = word_width_select_bit ? rxs_nxt : {8'h00, rxs_nxt[7:0]};
    ovf = done && rcnt_r == cap;
  end

  // Transfer engine
  always_comb
  begin
    st_nxt = st_r;
    sr_nxt = sr_r;
    bit_nxt = bit_r;
    tog_nxt = tog_r;
    div_nxt = div_r;
    sck_nxt = sck_r;
    sdo_nxt = sdo_r;
    if (!en_r)
    begin
      st_nxt = XF_IDLE;
      bit_nxt = '0;
      tog_nxt = '0;
      div_nxt = '0;
      sck_nxt = ckp;
    end
    else if (run)
    begin
      if (load)
      begin
        sr_nxt = word_width_select_bit ? tx_mem[trp_r] : {tx_mem[trp_r][7:0], 8'h00};
        sdo_nxt = word_width_select_bit ? tx_mem[trp_r][15] : tx_mem[trp_r][7];
        st_nxt = XF_RUN;
        tog_nxt = '0;
        div_nxt = '0;
      end
      if (master_select_bit && st_r == XF_RUN)
      begin
        div_nxt = div_wrap ? 8'h00 : div_r + 8'h01;
        if (div_wrap && tog_r != 6'({nbits, 1'b0}))
        begin
          sck_nxt = !sck_r;
          tog_nxt = tog_r + 6'h01;
        end
      end
      if (shft && !load)
      begin
        sr_nxt = {sr_r[14:0], 1'b0};
        sdo_nxt = sr_r[14];
      end
      if (samp)
      begin
        bit_nxt = bit_r + 5'h01;
      end
      if (!master_select_bit && !sel)
      begin
        bit_nxt = '0;
      end
      if (done)
      begin
        st_nxt = XF_IDLE;
        bit_nxt = '0;
      end
    end
  end

  // Buffers, status and register access
  always_comb
  begin
    en_nxt = en_r;
    sidl_nxt = sidl_r;
    buffer_interrupt_mode_nxt = buffer_interrupt_mode_r;
    con1_nxt = con1_r;
    con2_nxt = con2_r;
    hrdata_nxt = hrdata_r;
    rov_nxt = rov_r;
    twp_nxt = twp_r + AW'(push);
    trp_nxt = trp_r + AW'(load);
    rwp_nxt = rwp_r + AW'(done && !ovf);
    rrp_nxt = rrp_r + AW'(pop);
    tcnt_nxt = tcnt_r + CW'(push) - CW'(load);
    rcnt_nxt = rcnt_r + CW'(done && !ovf) - CW'(pop);
    if (pend_r && pw_r)
    begin
      case (pa_r)
        STAT_OFS:
        begin
          en_nxt = hwdata[EN_BIT];
          sidl_nxt = hwdata[SIDL_BIT];
          buffer_interrupt_mode_nxt = hwdata[BUFFER_INTERRUPT_MODE_LSB+:3];
          rov_nxt = rov_r & hwdata[ROV_BIT];
        end
        CON1_OFS: con1_nxt = hwdata[15:0] & CON1_MASK;
        CON2_OFS: con2_nxt = hwdata[15:0] & CON2_MASK;
        default: ;
      endcase
    end
    if (ovf)
    begin
      rov_nxt = 1'b1;
    end
    if (!en_r)
    begin
      twp_nxt = '0;
      trp_nxt = '0;
      rwp_nxt = '0;
      rrp_nxt = '0;
      tcnt_nxt = '0;
      rcnt_nxt = '0;
    end
    if (pend_r && !pw_r)
    begin
      case (pa_r)
        STAT_OFS: hrdata_nxt = {16'h0000, en_r, 1'b0, sidl_r, 2'b00,
                                master_select_bit ? tcnt_r[2:0] : rcnt_r[2:0],
                                st_r == XF_IDLE, rov_r, rcnt_r == '0,
                                buffer_interrupt_mode_r, tcnt_r == cap, rcnt_r == cap};
        CON1_OFS: hrdata_nxt = {16'h0000, con1_r};
        CON2_OFS: hrdata_nxt = {16'h0000, con2_r};
        BUF_OFS: hrdata_nxt = {16'h0000, rx_mem[rrp_r]};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    case (buffer_interrupt_mode_t'(buffer_interrupt_mode_r))
      SI_TX_FULL: evt_nxt = tcnt_r == cap;
      SI_TX_LAST: evt_nxt = done && tcnt_r == '0;
      SI_TX_DONE: evt_nxt = done;
      SI_TX_MOVED: evt_nxt = load;
      SI_RX_FULL: evt_nxt = rcnt_r == cap;
      SI_RX_3Q: evt_nxt = {rcnt_r, 2'b00} >= {1'b0, cap, 1'b0} + {2'b00, cap};
      SI_RX_AVAIL: evt_nxt = rcnt_r != '0;
      SI_RX_EMPTIED: evt_nxt = pop && rcnt_r == CW'(1);
      default: evt_nxt = 1'b0;
    endcase
    if (!en_r)
    begin
      evt_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      tx_mem[twp_r] <= hwdata[15:0];
    end
    if (done && !ovf)
    begin
      rx_mem[rwp_r] <= rx_word;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      pend_r <= 1'b0;
      pw_r <= 1'b0;
      pa_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      en_r <= 1'b0;
      sidl_r <= 1'b0;
      buffer_interrupt_mode_r <= 3'h0;
      rov_r <= 1'b0;
      evt_r <= 1'b0;
      con1_r <= CON_RESET;
      con2_r <= CON_RESET;
      twp_r <= '0;
      trp_r <= '0;
      rwp_r <= '0;
      rrp_r <= '0;
      tcnt_r <= '0;
      rcnt_r <= '0;
      st_r <= XF_IDLE;
      sr_r <= 16'h0000;
      rxs_r <= 16'h0000;
      bit_r <= 5'h00;
      tog_r <= 6'h00;
      div_r <= 8'h00;
      sck_r <= 1'b0;
      prev_r <= 1'b0;
      sdo_r <= 1'b0;
      sck_oe_r <= 1'b1;
      sdo_oe_r <= 1'b1;
    end
    else
    begin
      sy1_r <= {slave_select_pin_n, serial_data_in_pin, shift_clock_pin_in};
      sy2_r <= sy1_r;
      // One wait state: the data phase completes on the second edge
      pend_r <= hsel && htrans[1] && hready && hready_r;
      hready_r <= !(hsel && htrans[1] && hready && hready_r);
      if (hsel && htrans[1] && hready && hready_r)
      begin
        pw_r <= hwrite;
        pa_r <= haddr[7:0];
      end
      hrdata_r <= hrdata_nxt;
      en_r <= en_nxt;
      sidl_r <= sidl_nxt;
      buffer_interrupt_mode_r <= buffer_interrupt_mode_nxt;
      rov_r <= rov_nxt;
      evt_r <= evt_nxt;
      con1_r <= con1_nxt;
      con2_r <= con2_nxt;
      twp_r <= twp_nxt;
      trp_r <= trp_nxt;
      rwp_r <= rwp_nxt;
      rrp_r <= rrp_nxt;
      tcnt_r <= tcnt_nxt;
      rcnt_r <= rcnt_nxt;
      st_r <= st_nxt;
      sr_r <= sr_nxt;
      rxs_r <= en_r ? rxs_nxt : 16'h0000;
      bit_r <= bit_nxt;
      tog_r <= tog_nxt;
      div_r <= div_nxt;
      sck_r <= sck_nxt;
      prev_r <= lvl;
      sdo_r <= sdo_nxt;
      sck_oe_r <= !(en_r && master_select_bit);
      sdo_oe_r <= !(en_r && (master_select_bit || sel));
    end
  end

  chk_master_start: assert property ((load && master_select_bit) |-> ##[1:20] $changed(sck_r))
    else $error("master did not start clocking after buffer write");
  chk_ovf_set: assert property (ovf |=> rov_r && $stable(rcnt_r))
    else $error("overflow not flagged or word not dropped");
  chk_ovf_sticky: assert property ((rov_r && !wr_stat) |=> rov_r)
    else $error("overflow flag cleared without software");
  chk_std_txfull: assert property ((en_r && !ben && push && !load) |=> tcnt_r == 1)
    else $error("standard transmit full not set by write");
  chk_std_rxfull: assert property ((!ben && done && rcnt_r == 0 && !pop) |=> rcnt_r == 1)
    else $error("standard receive full not set by transfer");
  chk_disable_pins: assert property (!en_r |=> st_r == XF_IDLE && sck_oe_r && sdo_oe_r)
    else $error("disabled module still owns pins");
  chk_idle_halt: assert property ((!run && en_r) |=> $stable(sck_r) && $stable(bit_r))
    else $error("shifting continued while stopped in idle");
  chk_fifo_bound: assert property (tcnt_r <= cap && rcnt_r <= cap)
    else $error("buffer count beyond its capacity");
  chk_resv_zero: assert property ((pend_r && !pw_r && pa_r == STAT_OFS)
    |=> hrdata_r[14] == 1'b0 && hrdata_r[12:11] == 2'b00 && hready_r)
    else $error("unused status bits not zero");
  chk_fifo_order: assert property ((pop && rcnt_r > 1) |=> rrp_r == $past(rrp_r) + AW'(1))
    else $error("receive read did not advance to next word");
endmodule // spi_buffer_status_control
`default_nettype wire

// *** spi_peer_model.sv ***
// Serial peer answering the block when it is master, and driving it as master when it is slave
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic sck_m,
  output logic ss_n
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [7:0] q[$];
  logic [7:0] got[$];
  int cnt = 0;
  bit busy = 0;
  initial
  begin
    miso = 1'b0;
    sck_m = 1'b0;
    ss_n = 1'b1;
  end
  task push(input logic [7:0] b);
    if (busy)
      q.push_back(b);
    else
    begin
      sh = b;
      miso = b[7];
      busy = 1;
    end
  endtask
  // Act as master for one byte: select, 8 clocks, MSB first, sample on rise
  task automatic frame(input logic [7:0] tx, output logic [7:0] rv);
    #3 ss_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      miso = tx[i];
      #80 sck_m = 1'b1;
      rv = {rv[6:0], mosi};
      #80 sck_m = 1'b0;
    end
    #80 ss_n = 1'b1;
  endtask
  always @(posedge sck)
    rx = {rx[6:0], mosi};
  // Shift out on the falling edge; line toggles on each falling edge while no byte is queued
  always @(negedge sck)
  begin
    cnt = cnt + 1;
    sh = {sh[6:0], 1'b0};
    if (cnt == 8)
    begin
      cnt = 0;
      got.push_back(rx);
      busy = q.size() > 0;
      if (busy)
        sh = q.pop_front();
    end
    miso = busy ? sh[7] : ~miso;
  end
endmodule // spi_peer_model
`default_nettype wire

// *** spi_buffer_status_control_tb.sv ***
// Self-checking bench for the buffered serial port
`timescale 1ns/1ps
`default_nettype none
module spi_buffer_status_control_tb;
  import spi_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout, hresp, sck, sck_oe_n, sdo, sdo_oe_n, sdi, bev;
  logic [7:0] tx_q[$];
  logic [7:0] rep_q[$];
  logic idle = 1'b0;
  logic s_sck;
  logic p_sck, p_ss_n;
  logic [7:0] sw, mb, sb;
  int bad_count = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  spi_buffer_status_control #(.SCK_HALF(8)) dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .idle_mode(idle), .shift_clock_pin_in(p_sck), .shift_clock_pin_out(sck),
    .shift_clock_pin_oe_n(sck_oe_n), .serial_data_out_pin(sdo), .serial_data_out_pin_oe_n(sdo_oe_n),
    .serial_data_in_pin(sdi), .slave_select_pin_n(p_ss_n), .buffer_event(bev)
  );
  spi_peer_model peer (.sck(sck), .mosi(sdo), .miso(sdi), .sck_m(p_sck), .ss_n(p_ss_n));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("%0d checks, %0d wrong", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      test_done;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Queue bytes for both ends, then write them to the buffer
  task put(input int k);
    logic [7:0] b;
    repeat (k)
    begin
      b = 8'($urandom);
      peer.push(b ^ 8'h3C);
      rep_q.push_back(b ^ 8'h3C);
      tx_q.push_back(b);
      bus(1'b1, BUF_OFS, {24'h0, b});
    end
  endtask
  task xfer;
    int n;
    n = 0;
    while (peer.got.size() < tx_q.size() && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      bad_count++;
      test_done;
    end
    repeat (20) @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(32'h6eec9753));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({sck_oe_n, sdo_oe_n, hresp}, 3'b110);
    rd(STAT_OFS);
    chk(r & 32'hF843, 32'h0);
    rd(CON1_OFS);
    chk(r, {16'h0, CON_RESET});
    rd(8'h10);
    chk(r, 32'h0);
    bus(1'b1, STAT_OFS, 32'h5800);
    rd(STAT_OFS);
    chk(r & 32'h5800, 32'h0);
    $display("reset test done");
    bus(1'b1, STAT_OFS, 32'h0004);
    bus(1'b1, CON1_OFS, 32'h0120);
    bus(1'b1, CON2_OFS, 32'h0);
    bus(1'b1, STAT_OFS, 32'h0004);
    bus(1'b1, STAT_OFS, 32'hA004);
    put(1);
    repeat (30) @(posedge clk);
    idle <= 1'b1;
    repeat (2) @(posedge clk);
    s_sck = sck;
    repeat (40) @(posedge clk);
    chk(sck, s_sck);
    rd(STAT_OFS);
    chk(r & 32'h2080, 32'h2000);
    idle <= 1'b0;
    xfer;
    rd(STAT_OFS);
    chk(r & 32'hF8C3, 32'hA081);
    chk(bev, 1'b1);
    chk({sck_oe_n, sdo_oe_n}, 2'b00);
    put(1);
    xfer;
    rd(STAT_OFS);
    chk(r & 32'hF8C3, 32'hA0C1);
    rd(BUF_OFS);
    chk(r, {24'h0, rep_q.pop_front()});
    rep_q.delete(0);
    bus(1'b1, STAT_OFS, 32'h8004);
    rd(STAT_OFS);
    chk(r & 32'hF8C3, 32'h8080);
    chk(bev, 1'b0);
    $display("standard test done");
    bus(1'b1, STAT_OFS, 32'h0);
    bus(1'b1, CON2_OFS, 32'h1);
    bus(1'b1, STAT_OFS, 32'h801C);
    put(9);
    rd(STAT_OFS);
    chk(r, 32'h803E);
    chk(bev, 1'b1);
    xfer;
    rd(STAT_OFS);
    chk(r, 32'h80DD);
    bus(1'b1, STAT_OFS, 32'h804C);
    @(posedge clk);
    chk(bev, 1'b1);
    repeat (FIFO_DEPTH)
    begin
      rd(BUF_OFS);
      chk(r, {24'h0, rep_q.pop_front()});
    end
    rd(STAT_OFS);
    chk(r, 32'h80EC);
    chk(bev, 1'b0);
    foreach (tx_q[i])
      chk({24'h0, peer.got[i]}, {24'h0, tx_q[i]});
    $display("enhanced test done");
    bus(1'b1, STAT_OFS, 32'h0);
    bus(1'b1, CON2_OFS, 32'h0);
    bus(1'b1, BUF_OFS, 32'h0);
    bus(1'b1, CON1_OFS, 32'h0180);
    bus(1'b1, STAT_OFS, 32'h8004);
    sw = 8'($urandom);
    mb = 8'($urandom);
    bus(1'b1, BUF_OFS, {24'h0, sw});
    peer.frame(mb, sb);
    repeat (10) @(posedge clk);
    rd(STAT_OFS);
    chk(r, 32'h8185);
    chk({sck_oe_n, sdo_oe_n}, 2'b11);
    rd(BUF_OFS);
    chk(r, {24'h0, mb});
    chk({24'h0, sb}, {24'h0, sw});
    $display("slave test done");
    test_done;
  end
endmodule // spi_buffer_status_control_tb
`default_nettype wire
